// ### rtl/fram_write_protect_status.sv
// Serial command front end with write protection and status registers
`timescale 1ns/1ps
module fram_write_protect_status (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic wp_n,
  input wire logic crc_done,
  output logic so,
  output logic so_oe,
  output logic mem_wr_en,
  output fwp_pkg::mem_wr_t mem_wr,
  output logic crc_start,
  output fwp_pkg::crc_req_t crc_req,
  output logic crc_hold
);
  // ***************************************************
  // Helper functions
  // ***************************************************
  // Range size doubles with each code step from 001 upward; 111 covers everything
  function automatic logic is_protected(input logic [2:0] bp,
                                        input logic tb,
                                        input logic [17:0] a);
    logic [18:0] size;
    size = 19'h0;
    if (bp == 3'h7) begin
      size = fwp_pkg::ARRAY_SIZE;
    end else if (bp != 3'h0) begin
      size = 19'(fwp_pkg::BLOCK_UNIT << (bp - 3'h1));
    end
    if (tb) begin
      return {1'b0, a} < size;
    end
    return {1'b0, a} >= (fwp_pkg::ARRAY_SIZE - size);
  endfunction

  function automatic logic busy_ok(input logic [7:0] op);
    return op == fwp_pkg::STATUS1_READ_CMD ||
           op == fwp_pkg::STATUS2_READ_CMD ||
           op == fwp_pkg::ANY_REGISTER_READ_CMD ||
           op == fwp_pkg::CRC_SUSPEND_CMD ||
           op == fwp_pkg::RESET_ARM_CMD ||
           op == fwp_pkg::RESET_GO_CMD;
  endfunction

  function automatic logic clears_wel(input logic [7:0] op);
    return op == fwp_pkg::WRITE_DISABLE_CMD ||
           op == fwp_pkg::STATUS_WRITE_CMD ||
           op == fwp_pkg::SPECIAL_SECTOR_WRITE_CMD ||
           op == fwp_pkg::ANY_REGISTER_WRITE_CMD ||
           op == fwp_pkg::SERIAL_NUMBER_WRITE_CMD;
  endfunction

  function automatic logic [2:0] addr_len(input logic [7:0] op);
    if (op == fwp_pkg::CRC_CALC_CMD) begin
      return fwp_pkg::CRC_ADDR_BYTES;
    end
    if (op == fwp_pkg::MEM_WRITE_CMD ||
        op == fwp_pkg::ANY_REGISTER_READ_CMD ||
        op == fwp_pkg::ANY_REGISTER_WRITE_CMD ||
        op == fwp_pkg::SPECIAL_SECTOR_WRITE_CMD) begin
      return fwp_pkg::ADDR_BYTES;
    end
    return 3'h0;
  endfunction

  // Either address of a status register selects it
  function automatic logic [1:0] reg_sel(input logic [23:0] a);
    if (a == fwp_pkg::STATUS1_NV_ADDR || a == fwp_pkg::STATUS1_V_ADDR) begin
      return fwp_pkg::SEL_S1;
    end
    if (a == fwp_pkg::STATUS2_NV_ADDR || a == fwp_pkg::STATUS2_V_ADDR) begin
      return fwp_pkg::SEL_S2;
    end
    return fwp_pkg::SEL_NONE;
  endfunction

  // ***************************************************
  // Pin sampling
  // ***************************************************
  logic [3:0] sy1, sy2, sy3, lvl, lvl_old, next_lvl;

  // A lane takes a new level only once stages two and three agree
  always_comb begin
    next_lvl = ((sy2 ~^ sy3) & sy3) | ((sy2 ^ sy3) & lvl);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sy1 <= fwp_pkg::PIN_IDLE;
      sy2 <= fwp_pkg::PIN_IDLE;
      sy3 <= fwp_pkg::PIN_IDLE;
      lvl <= fwp_pkg::PIN_IDLE;
      lvl_old <= fwp_pkg::PIN_IDLE;
    end else begin
      sy1 <= {wp_n, si, sck, cs_n};
      sy2 <= sy1;
      sy3 <= sy2;
      lvl <= next_lvl;
      lvl_old <= lvl;
    end
  end

  // ***************************************************
  // Command engine
  // ***************************************************
  fwp_pkg::ctl_t s, n;
  logic sck_rise, sck_fall, cs_rise, cs_high, lock, fin, byte_done;
  logic [7:0] in_byte, stat1_byte, stat2_byte, tx_b;

  // Edge events on the agreed levels
  assign cs_high = lvl[fwp_pkg::PIN_CS];
  assign cs_rise = cs_high & ~lvl_old[fwp_pkg::PIN_CS];
  assign sck_rise = lvl[fwp_pkg::PIN_SCK] & ~lvl_old[fwp_pkg::PIN_SCK];
  assign sck_fall = ~lvl[fwp_pkg::PIN_SCK] & lvl_old[fwp_pkg::PIN_SCK];
  assign lock = s.status_write_disable & ~lvl[fwp_pkg::PIN_WP];
  assign fin = cs_rise & s.op_valid;
  assign in_byte = {s.shift[6:0], lvl[fwp_pkg::PIN_SI]};
  assign byte_done = sck_rise & ~cs_high & (s.bit_cnt == 3'h7);

  // Only the live copy exists here, so reads always see it
  always_comb begin
    stat1_byte = fwp_pkg::STATUS1_RESET;
    stat1_byte[fwp_pkg::SWD_BIT] = s.status_write_disable;
    stat1_byte[fwp_pkg::TB_BIT] = s.top_bottom_select;
    stat1_byte[fwp_pkg::BP_MSB:fwp_pkg::BP_LSB] = s.block_protect;
    stat1_byte[fwp_pkg::LATCH_BIT] = s.write_enable_latch;
    stat1_byte[fwp_pkg::BUSY_BIT] = s.busy_flag;
    stat2_byte = fwp_pkg::STATUS2_RESET;
    stat2_byte[fwp_pkg::SUSP_BIT] = s.crc_suspended_flag;
    stat2_byte[fwp_pkg::ABRT_BIT] = s.crc_aborted_flag;
  end

  // Next state; later statements win, so every set beats a clear
  always_comb begin
    n = s;
    tx_b = 8'h00;
    n.mem_wr_en = 1'b0;
    n.crc_start = 1'b0;
    if (crc_done && s.busy_flag) begin
      n.busy_flag = 1'b0;
    end
    if (sck_rise && !cs_high) begin
      n.bit_cnt = s.bit_cnt + 3'h1;
      n.shift = in_byte;
    end
    if (byte_done) begin
      unique case (s.phase)
        fwp_pkg::PH_CMD: begin
          n.opcode = in_byte;
          n.addr_cnt = 3'h0;
          n.data_seen = 1'b0;
          if (s.busy_flag && !busy_ok(in_byte)) begin
            n.phase = fwp_pkg::PH_SKIP;
          end else begin
            n.op_valid = 1'b1;
            n.phase = (addr_len(in_byte) == 3'h0) ? fwp_pkg::PH_DATA
                                                   : fwp_pkg::PH_ADDR;
            if (in_byte == fwp_pkg::STATUS1_READ_CMD) begin
              n.rd_sel = fwp_pkg::SEL_S1;
            end else if (in_byte == fwp_pkg::STATUS2_READ_CMD) begin
              n.rd_sel = fwp_pkg::SEL_S2;
            end
          end
        end
        fwp_pkg::PH_ADDR: begin
          if (s.addr_cnt < fwp_pkg::ADDR_BYTES) begin
            n.addr = {s.addr[15:0], in_byte};
          end else begin
            n.end_addr = {s.end_addr[15:0], in_byte};
          end
          n.addr_cnt = s.addr_cnt + 3'h1;
          if (n.addr_cnt == addr_len(s.opcode)) begin
            n.phase = fwp_pkg::PH_DATA;
          end
          // Unmapped register reads select nothing, so no data is shifted out
          if (s.opcode == fwp_pkg::ANY_REGISTER_READ_CMD) begin
            n.rd_sel = reg_sel(n.addr);
          end
        end
        fwp_pkg::PH_DATA: begin
          // Refused bytes are dropped with no trace
          if (s.opcode == fwp_pkg::MEM_WRITE_CMD) begin
            if (s.write_enable_latch &&
                !is_protected(s.block_protect, s.top_bottom_select,
                              s.addr[17:0])) begin
              n.mem_wr_en = 1'b1;
              n.mem_wr = '{addr: s.addr[17:0], data: in_byte};
            end
            n.addr = s.addr + 24'h1;
          end
          // Only the first data byte of a register write counts
          if (!s.data_seen && s.write_enable_latch && !lock &&
              (s.opcode == fwp_pkg::STATUS_WRITE_CMD ||
               (s.opcode == fwp_pkg::ANY_REGISTER_WRITE_CMD &&
                reg_sel(s.addr) == fwp_pkg::SEL_S1))) begin
            n.status_write_disable = in_byte[fwp_pkg::SWD_BIT];
            n.top_bottom_select = in_byte[fwp_pkg::TB_BIT];
            n.block_protect = in_byte[fwp_pkg::BP_MSB:fwp_pkg::BP_LSB];
          end
          n.data_seen = 1'b1;
        end
        fwp_pkg::PH_SKIP: begin
          n.phase = fwp_pkg::PH_SKIP;
        end
      endcase
    end
    // Byte boundary reloads the live register so polling tracks it
    if (sck_fall && !cs_high && s.rd_sel != fwp_pkg::SEL_NONE) begin
      if (s.tx_bit != 3'h0) begin
        tx_b = s.tx;
      end else if (s.rd_sel == fwp_pkg::SEL_S1) begin
        tx_b = stat1_byte;
      end else begin
        tx_b = stat2_byte;
      end
      n.so = tx_b[7];
      n.tx = {tx_b[6:0], 1'b0};
      n.tx_bit = s.tx_bit + 3'h1;
      n.so_oe = 1'b1;
    end
    // Commands execute on deselect
    if (fin) begin
      if (clears_wel(s.opcode)) begin
        n.write_enable_latch = 1'b0;
      end
      if (s.opcode == fwp_pkg::WRITE_ENABLE_CMD) begin
        n.write_enable_latch = 1'b1;
      end
      n.rst_armed = (s.opcode == fwp_pkg::RESET_ARM_CMD);
      if (s.opcode == fwp_pkg::CRC_SUSPEND_CMD && s.busy_flag) begin
        n.crc_suspended_flag = 1'b1;
        n.busy_flag = 1'b0;
        n.crc_hold = 1'b1;
      end
      if (s.opcode == fwp_pkg::CRC_RESUME_CMD && s.crc_suspended_flag) begin
        n.crc_suspended_flag = 1'b0;
        n.busy_flag = 1'b1;
        n.crc_hold = 1'b0;
      end
      if (s.opcode == fwp_pkg::CRC_CALC_CMD &&
          s.addr_cnt == fwp_pkg::CRC_ADDR_BYTES) begin
        if ({1'b0, s.end_addr} < {1'b0, s.addr} + fwp_pkg::CRC_MIN_SPAN)
        begin
          n.crc_aborted_flag = 1'b1;
        end else begin
          n.crc_aborted_flag = 1'b0;
          n.busy_flag = 1'b1;
          n.crc_start = 1'b1;
          n.crc_req = '{first: s.addr, last: s.end_addr};
        end
      end
      // Software reset; protect settings are kept
      if (s.opcode == fwp_pkg::RESET_GO_CMD && s.rst_armed) begin
        n.write_enable_latch = 1'b0;
        n.busy_flag = 1'b0;
        n.crc_suspended_flag = 1'b0;
        n.crc_aborted_flag = 1'b0;
        n.crc_hold = 1'b0;
        n.rst_armed = 1'b0;
      end
    end
    if (cs_high) begin
      n.phase = fwp_pkg::PH_CMD;
      n.bit_cnt = 3'h0;
      n.op_valid = 1'b0;
      n.rd_sel = fwp_pkg::SEL_NONE;
      n.tx_bit = 3'h0;
      n.so_oe = 1'b0;
    end
  end

  // Power-on and pin reset clear all volatile state
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= fwp_pkg::CTL_RESET;
    end else begin
      s <= n;
    end
  end

  assign so = s.so;
  assign so_oe = s.so_oe;
  assign mem_wr_en = s.mem_wr_en;
  assign mem_wr = s.mem_wr;
  assign crc_start = s.crc_start;
  assign crc_req = s.crc_req;
  assign crc_hold = s.crc_hold;

  // ***************************************************
  // Assertions
  // ***************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_latch_set_src: assert property (
    $rose(s.write_enable_latch) |->
      $past(fin && s.opcode == fwp_pkg::WRITE_ENABLE_CMD))
    else $error("latch set without enable command");
  a_latch_clear_cmd: assert property (
    fin && clears_wel(s.opcode) |=> !s.write_enable_latch)
    else $error("latch not cleared at deselect");
  a_latch_keep_mem: assert property (
    fin && s.opcode == fwp_pkg::MEM_WRITE_CMD && s.write_enable_latch
      |=> s.write_enable_latch)
    else $error("latch lost after array write");
  a_write_needs_latch: assert property (
    s.mem_wr_en |-> $past(s.write_enable_latch))
    else $error("array write with latch clear");
  a_write_unprotected: assert property (
    s.mem_wr_en |-> !is_protected($past(s.block_protect),
      $past(s.top_bottom_select), s.mem_wr.addr))
    else $error("write inside protected range");
  a_status_locked: assert property (
    s.status_write_disable && !lvl[fwp_pkg::PIN_WP] |=>
      s.status_write_disable && $stable(s.block_protect) &&
      $stable(s.top_bottom_select))
    else $error("locked status changed");
  a_busy_source: assert property (
    $rose(s.busy_flag) |-> $past(fin &&
      (s.opcode == fwp_pkg::CRC_CALC_CMD ||
       s.opcode == fwp_pkg::CRC_RESUME_CMD)))
    else $error("busy set outside CRC");
  a_busy_gate: assert property (
    s.busy_flag && byte_done && s.phase == fwp_pkg::PH_CMD &&
      !busy_ok(in_byte) |=> s.phase == fwp_pkg::PH_SKIP || cs_high)
    else $error("command accepted while busy");
  a_abort_span: assert property (
    fin && s.opcode == fwp_pkg::CRC_CALC_CMD &&
      s.addr_cnt == fwp_pkg::CRC_ADDR_BYTES |=> s.crc_aborted_flag ==
      ({1'b0, $past(s.end_addr)} <
       {1'b0, $past(s.addr)} + fwp_pkg::CRC_MIN_SPAN))
    else $error("abort flag wrong for span");
  a_suspend_set: assert property (
    fin && s.opcode == fwp_pkg::CRC_SUSPEND_CMD && s.busy_flag
      |=> s.crc_suspended_flag && !s.busy_flag)
    else $error("suspend not flagged");
  a_resume_clear: assert property (
    fin && s.opcode == fwp_pkg::CRC_RESUME_CMD |=> !s.crc_suspended_flag)
    else $error("suspend flag not cleared");
  a_soft_reset: assert property (
    fin && s.opcode == fwp_pkg::RESET_GO_CMD && s.rst_armed |=>
      !s.write_enable_latch && !s.busy_flag && !s.crc_suspended_flag)
    else $error("soft reset left state");

  c_mem_write: cover property (s.mem_wr_en);
  c_crc_start: cover property (s.crc_start);
  c_suspend: cover property ($rose(s.crc_suspended_flag));
  c_status_wr: cover property (fin && !lock &&
    s.opcode == fwp_pkg::STATUS_WRITE_CMD);
endmodule

// ### rtl/fwp_pkg.sv
// Constants and carrier types for the write-protect and status block
package fwp_pkg;
  // Opcodes
  localparam logic [7:0] WRITE_ENABLE_CMD = 8'h06;
  localparam logic [7:0] WRITE_DISABLE_CMD = 8'h04;
  localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
  localparam logic [7:0] SPECIAL_SECTOR_WRITE_CMD = 8'h42;
  localparam logic [7:0] ANY_REGISTER_WRITE_CMD = 8'h71;
  localparam logic [7:0] SERIAL_NUMBER_WRITE_CMD = 8'hc2;
  localparam logic [7:0] STATUS1_READ_CMD = 8'h05;
  localparam logic [7:0] STATUS2_READ_CMD = 8'h07;
  localparam logic [7:0] ANY_REGISTER_READ_CMD = 8'h65;
  localparam logic [7:0] CRC_SUSPEND_CMD = 8'hb0;
  localparam logic [7:0] CRC_RESUME_CMD = 8'h30;
  localparam logic [7:0] RESET_ARM_CMD = 8'h66;
  localparam logic [7:0] RESET_GO_CMD = 8'h99;
  localparam logic [7:0] MEM_WRITE_CMD = 8'h02;
  localparam logic [7:0] CRC_CALC_CMD = 8'h5b;
  // Register addresses for the any-register commands
  localparam logic [23:0] STATUS1_NV_ADDR = 24'h000000;
  localparam logic [23:0] STATUS1_V_ADDR = 24'h070000;
  localparam logic [23:0] STATUS2_NV_ADDR = 24'h000001;
  localparam logic [23:0] STATUS2_V_ADDR = 24'h070001;
  // Field positions and reset values
  localparam int SWD_BIT = 7;
  localparam int TB_BIT = 5;
  localparam int BP_MSB = 4;
  localparam int BP_LSB = 2;
  localparam int LATCH_BIT = 1;
  localparam int BUSY_BIT = 0;
  localparam int SUSP_BIT = 4;
  localparam int ABRT_BIT = 3;
  localparam logic [7:0] STATUS1_RESET = 8'h00;
  localparam logic [7:0] STATUS2_RESET = 8'h00;
  // Array geometry and CRC span
  localparam logic [18:0] ARRAY_SIZE = 19'h40000;
  localparam logic [18:0] BLOCK_UNIT = 19'h01000;
  localparam logic [24:0] CRC_MIN_SPAN = 25'h0000003;
  localparam logic [2:0] ADDR_BYTES = 3'h3;
  localparam logic [2:0] CRC_ADDR_BYTES = 3'h6;
  // Pin sampler lanes and idle levels
  localparam int PIN_CS = 0;
  localparam int PIN_SCK = 1;
  localparam int PIN_SI = 2;
  localparam int PIN_WP = 3;
  localparam logic [3:0] PIN_IDLE = 4'h9;
  // Read selection
  localparam logic [1:0] SEL_NONE = 2'h0;
  localparam logic [1:0] SEL_S1 = 2'h1;
  localparam logic [1:0] SEL_S2 = 2'h2;

  typedef enum logic [3:0] {
    PH_CMD = 4'b0001,
    PH_ADDR = 4'b0010,
    PH_DATA = 4'b0100,
    PH_SKIP = 4'b1000
  } phase_t;

  typedef struct packed {
    logic [17:0] addr;
    logic [7:0] data;
  } mem_wr_t;

  typedef struct packed {
    logic [23:0] first;
    logic [23:0] last;
  } crc_req_t;

  typedef struct packed {
    phase_t phase;
    logic [2:0] bit_cnt;
    logic [7:0] shift;
    logic [7:0] opcode;
    logic [23:0] addr;
    logic [23:0] end_addr;
    logic [2:0] addr_cnt;
    logic op_valid;
    logic data_seen;
    logic status_write_disable;
    logic top_bottom_select;
    logic [2:0] block_protect;
    logic write_enable_latch;
    logic busy_flag;
    logic crc_suspended_flag;
    logic crc_aborted_flag;
    logic rst_armed;
    logic [1:0] rd_sel;
    logic [7:0] tx;
    logic [2:0] tx_bit;
    logic so;
    logic so_oe;
    logic mem_wr_en;
    mem_wr_t mem_wr;
    logic crc_start;
    logic crc_hold;
    crc_req_t crc_req;
  } ctl_t;

  localparam ctl_t CTL_RESET = '{phase: PH_CMD, default: '0};
endpackage

// ### bench/spi_host_model.sv
// Host serial controller model that frames commands on the link pins
`timescale 1ns/1ps
module spi_host_model (
  input wire logic clk,
  output logic cs_n,
  output logic sck,
  output logic si,
  input wire logic so
);
  // ****************************************
  // Framing
  // ****************************************
  // Idle pins: deselected, clock parked low as mode 0 wants
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b1;
  end

  // Sends the top n bytes of tx MSB first, gathers so at each rise
  task automatic frame(input int n, input logic [63:0] tx,
                       output logic [63:0] rx);
    // Quarter step after a core edge keeps every pin change off the
    // core sampling edges for the whole frame
    @(posedge clk);
    #0.25;
    rx = '0;
    cs_n = 1'b0;
    for (int i = 0; i < n * 8; i++) begin
      si = tx[63 - i];
      #62.5 sck = 1'b1;
      rx = {rx[62:0], so};
      #62.5 sck = 1'b0;
    end
    #62.5 cs_n = 1'b1;
    // Released line shows the opposite level, never a stale bit
    si = ~si;
    // Deselect gap kept far above the six core cycles required
    #250;
  endtask
endmodule

// ### bench/fram_write_protect_status_tb.sv
// Self-checking bench for the write-protect and status block
`timescale 1ns/1ps
module fram_write_protect_status_tb;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic wp_n = 1'b1;
  logic crc_done = 1'b0;
  logic cs_n, sck, si, so, so_oe, so_line, mem_wr_en, crc_start, crc_hold;
  fwp_pkg::mem_wr_t mem_wr;
  fwp_pkg::mem_wr_t last_wr;
  fwp_pkg::crc_req_t crc_req;
  int err_count = 0;
  int samples_checked = 0;
  int wr_cnt = 0;
  int crc_cnt = 0;
  int w0;
  logic [63:0] rx;
  logic [7:0] v;
  logic [7:0] sr;
  logic [27:0] row;
  logic [17:0] a;
  // Rows: flags (bit1 write expected, bit0 bottom), code, address
  logic [27:0] rows [16] = '{
    28'h213efff, 28'h013f000, 28'h023e000, 28'h233bfff,
    28'h261ffff, 28'h0620000, 28'h203ffff, 28'h0700000,
    28'h1100fff, 28'h3101000, 28'h1407fff, 28'h3408000,
    28'h3510000, 28'h161ffff, 28'h3620000, 28'h173ffff};
  // Commands that must drop the latch when the frame closes
  logic [63:0] ctx [5] = '{64'h0400000000000000, 64'h0100000000000000,
    64'h4200001055000000, 64'h71070001ff000000, 64'hc2ab000000000000};
  int cn [5] = '{1, 2, 5, 5, 2};

  // ****************************************
  // Harness
  // ****************************************
  // Core clock at 125 MHz
  always #4 core_clk = ~core_clk;

  fram_write_protect_status fram_write_protect_status_i (
    .core_clk(core_clk), .rst_n(rst_n), .cs_n(cs_n), .sck(sck),
    .si(si), .wp_n(wp_n), .crc_done(crc_done), .so(so), .so_oe(so_oe),
    .mem_wr_en(mem_wr_en), .mem_wr(mem_wr), .crc_start(crc_start),
    .crc_req(crc_req), .crc_hold(crc_hold));

  // Undriven output shows the inverse, so a missing enable is caught
  assign so_line = so_oe ? so : ~so;

  spi_host_model spi_host_model_i (
    .clk(core_clk), .cs_n(cs_n), .sck(sck), .si(si), .so(so_line));

  // Pulses are counted here so no frame can miss one
  always @(posedge core_clk) begin
    if (mem_wr_en === 1'b1) begin
      wr_cnt++;
      last_wr = mem_wr;
    end
    if (crc_start === 1'b1) crc_cnt++;
  end

  task automatic chk(input string n, input logic [47:0] e,
                     input logic [47:0] g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic cmd(input logic [7:0] op);
    spi_host_model_i.frame(1, {op, 56'h0}, rx);
  endtask

  task automatic rd(input logic [7:0] op, output logic [7:0] r);
    spi_host_model_i.frame(2, {op, 56'h0}, rx);
    r = rx[7:0];
  endtask

  // Any-register read, data follows the address directly
  task automatic ard(input logic [23:0] ad, output logic [7:0] r);
    spi_host_model_i.frame(5, {fwp_pkg::ANY_REGISTER_READ_CMD, ad, 32'h0},
                           rx);
    r = rx[7:0];
  endtask

  task automatic s1(input string n, input logic [7:0] e);
    rd(fwp_pkg::STATUS1_READ_CMD, sr);
    chk(n, e, sr);
  endtask

  task automatic wsr(input logic [7:0] d);
    spi_host_model_i.frame(2, {fwp_pkg::STATUS_WRITE_CMD, d, 48'h0}, rx);
  endtask

  task automatic awr(input logic [17:0] ad, input logic [7:0] d);
    spi_host_model_i.frame(5, {fwp_pkg::MEM_WRITE_CMD, 6'h0, ad, d, 24'h0},
                           rx);
  endtask

  task automatic crc(input logic [23:0] s, input logic [23:0] e);
    spi_host_model_i.frame(7, {fwp_pkg::CRC_CALC_CMD, s, e, 8'h0}, rx);
  endtask

  task automatic pulse_done;
    @(posedge core_clk) crc_done <= 1'b1;
    @(posedge core_clk) crc_done <= 1'b0;
  endtask

  // Fixed wait after reset: busy is no guide while reset settles
  task automatic hreset;
    @(posedge core_clk) rst_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge core_clk);
  endtask

  task automatic test_done;
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Hang guard, well past the expected run yet under the cycle budget
  initial begin
    #700000;
    err_count++;
    test_done;
  end

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge core_clk);
    s1("status1 reset", 8'h00);
    rd(fwp_pkg::STATUS2_READ_CMD, v);
    chk("status2 reset", 8'h00, v);
    for (int i = 0; i < 5; i++) begin
      cmd(fwp_pkg::WRITE_ENABLE_CMD);
      s1("latch set", 8'h02);
      spi_host_model_i.frame(cn[i], ctx[i], rx);
      s1("latch cleared", 8'h00);
    end
    w0 = wr_cnt;
    awr(18'h00100, 8'h33);
    chk("write without latch", w0, wr_cnt);
    // Every code; codes 1, 6 and 7 at both ends; both sides of the boundary for codes 1, 4 and 6
    for (int i = 0; i < 16; i++) begin
      row = rows[i];
      a = row[17:0];
      cmd(fwp_pkg::WRITE_ENABLE_CMD);
      wsr({2'b00, row[24], row[22:20], 2'b00});
      s1("protect fields", {2'b00, row[24], row[22:20], 2'b00});
      cmd(fwp_pkg::WRITE_ENABLE_CMD);
      w0 = wr_cnt;
      awr(a, a[7:0] ^ 8'h5a);
      chk("write count", w0 + row[25], wr_cnt);
      if (row[25]) chk("write target", {a, a[7:0] ^ 8'h5a}, last_wr);
      s1("latch kept", {2'b00, row[24], row[22:20], 2'b10});
    end
    // Any-register write to the live first status copy
    cmd(fwp_pkg::WRITE_ENABLE_CMD);
    spi_host_model_i.frame(5, {fwp_pkg::ANY_REGISTER_WRITE_CMD,
                           fwp_pkg::STATUS1_V_ADDR, 8'h2c, 24'h0}, rx);
    s1("any write status1", 8'h2c);
    // Locked registers while the array stays writable
    cmd(fwp_pkg::WRITE_ENABLE_CMD);
    wsr(8'h80);
    @(posedge core_clk) wp_n <= 1'b0;
    cmd(fwp_pkg::WRITE_ENABLE_CMD);
    wsr(8'h84);
    rd(fwp_pkg::STATUS1_READ_CMD, v);
    chk("locked status", 8'h80, v & 8'hfd);
    cmd(fwp_pkg::WRITE_ENABLE_CMD);
    w0 = wr_cnt;
    awr(18'h3ffff, 8'hc3);
    chk("unprotected write", w0 + 1, wr_cnt);
    @(posedge core_clk) wp_n <= 1'b1;
    cmd(fwp_pkg::WRITE_ENABLE_CMD);
    wsr(8'h00);
    s1("unlocked status", 8'h00);
    // CRC run, refusals while busy, suspend and resume
    w0 = crc_cnt;
    crc(24'h000000, 24'h000010);
    chk("crc started", w0 + 1, crc_cnt);
    chk("crc span", {24'h000000, 24'h000010}, crc_req);
    s1("busy", 8'h01);
    cmd(fwp_pkg::WRITE_ENABLE_CMD);
    s1("busy refuses", 8'h01);
    ard(fwp_pkg::STATUS1_V_ADDR, v);
    chk("busy any read", 8'h01, v);
    cmd(fwp_pkg::CRC_SUSPEND_CMD);
    rd(fwp_pkg::STATUS2_READ_CMD, v);
    chk("suspend flag", 8'h10, v);
    chk("hold on", 1'b1, crc_hold);
    s1("suspended idle", 8'h00);
    cmd(fwp_pkg::CRC_RESUME_CMD);
    rd(fwp_pkg::STATUS2_READ_CMD, v);
    chk("resume flag", 8'h00, v);
    chk("hold off", 1'b0, crc_hold);
    s1("resumed busy", 8'h01);
    pulse_done;
    s1("crc finished", 8'h00);
    // Span one word short aborts, exact minimum starts
    w0 = crc_cnt;
    crc(24'h000100, 24'h000102);
    chk("abort no start", w0, crc_cnt);
    ard(fwp_pkg::STATUS2_V_ADDR, v);
    chk("abort flag v", 8'h08, v);
    ard(fwp_pkg::STATUS2_NV_ADDR, v);
    chk("abort flag nv", 8'h08, v);
    s1("abort not busy", 8'h00);
    cmd(fwp_pkg::WRITE_ENABLE_CMD);
    crc(24'h000100, 24'h000103);
    chk("min span start", w0 + 1, crc_cnt);
    rd(fwp_pkg::STATUS2_READ_CMD, v);
    chk("abort cleared", 8'h00, v);
    // Pin reset in mid calculation
    hreset;
    s1("pin reset", 8'h00);
    // Software reset pair while suspended
    cmd(fwp_pkg::WRITE_ENABLE_CMD);
    crc(24'h000000, 24'h000010);
    cmd(fwp_pkg::CRC_SUSPEND_CMD);
    cmd(fwp_pkg::RESET_ARM_CMD);
    cmd(fwp_pkg::RESET_GO_CMD);
    s1("soft reset status1", 8'h00);
    rd(fwp_pkg::STATUS2_READ_CMD, v);
    chk("soft reset status2", 8'h00, v);
    chk("soft reset hold", 1'b0, crc_hold);
    test_done;
  end
endmodule
